// >>> design/gpm_mapper.sv
`timescale 1ns/10ps
// ==========================================================================
// Pin bit mapper: five general pins under Wishbone registers

module gpm_mapper #(
  parameter int unsigned NPINS = gpm_pkg::NUM_PINS
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [10:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // General pins
  input  wire logic [NPINS-1:0]      general_pin_in,
  output logic      [NPINS-1:0]      general_pin_out,
  output logic      [NPINS-1:0]      general_pin_oe,
  // Selected host register bit address and value
  output logic      [NPINS-1:0][3:0] host_page_o,
  output logic      [NPINS-1:0][6:0] host_offset_o,
  output logic      [NPINS-1:0][2:0] host_bit_pos_o,
  input  wire logic [NPINS-1:0]      host_bit_i,
  // Controlled function
  output logic      [NPINS-1:0]      ctrl_value_o,
  output logic      [NPINS-1:0]      ctrl_apply_o
);

  // ========================================================================
  // Storage
  logic [15:0]      sel_reg [NPINS];
  logic [2:0]       mode_reg [NPINS];
  logic [NPINS-1:0] out_val_reg;
  logic [NPINS-1:0] pin_meta_reg;
  logic [NPINS-1:0] pin_sync_reg;
  logic [NPINS-1:0] in_status_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [8:0]       idx;
  logic             wr_take;
  logic             rd_start;

  assign idx      = wb_adr_i[10:2];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  // Writes land on the edge where the master sees ack, never earlier
  assign wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign rd_start = wb_cyc_i && wb_stb_i && !ack_reg;

  // Byte lane merge used for selector register writes
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  lanes);
    logic [15:0] res;
    res = old_v;
    if (lanes[0])
      res[7:0] = new_v[7:0];
    if (lanes[1])
      res[15:8] = new_v[15:8];
    return res;
  endfunction

  // ========================================================================
  // Pin input synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= general_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Input status shows sensed level only while the pin is in input mode
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      in_status_reg <= '0;
    else
      for (int p = 0; p < NPINS; p++)
        in_status_reg[p] <= (mode_reg[p] == gpm_pkg::GPM_MODE_INPUT) ?
                            pin_sync_reg[p] : in_status_reg[p];
  end

  // ========================================================================
  // Bus handshake: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end

  // Register writes; reserved bits are never stored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int p = 0; p < NPINS; p++)
      begin
        sel_reg[p]  <= gpm_pkg::SEL_RESET;
        mode_reg[p] <= gpm_pkg::MODE_RESET;
      end
      out_val_reg <= gpm_pkg::OUT_VAL_RESET;
    end
    else if (wr_take)
    begin
      for (int p = 0; p < NPINS; p++)
      begin
        if (idx == gpm_pkg::SEL_IDX[p])
          sel_reg[p] <= lane_merge(sel_reg[p], wb_dat_i[15:0], wb_sel_i[1:0])
                        & gpm_pkg::SEL_MASK;
        // Old mode holds until this very write lands
        if (idx == gpm_pkg::MODE_IDX[p] && wb_sel_i[0])
          mode_reg[p] <= wb_dat_i[2:0];
      end
      if (idx == gpm_pkg::OUT_VAL_IDX && wb_sel_i[0])
        out_val_reg <= wb_dat_i[NPINS-1:0];
    end
  end

  // Read decode; unmapped addresses answer with zero
  always_comb
  begin
    rdata_next = '0;
    for (int p = 0; p < NPINS; p++)
    begin
      if (idx == gpm_pkg::SEL_IDX[p])
        rdata_next[15:0] = sel_reg[p];
      if (idx == gpm_pkg::MODE_IDX[p])
        rdata_next[2:0] = mode_reg[p];
    end
    if (idx == gpm_pkg::OUT_VAL_IDX)
      rdata_next[NPINS-1:0] = out_val_reg;
    if (idx == gpm_pkg::IN_STATUS_IDX)
      rdata_next[NPINS-1:0] = in_status_reg;
  end

  // Read data is captured with the ack and held until the next request
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_reg <= '0;
    else if (rd_start)
      rdata_reg <= wb_we_i ? 32'h0000_0000 : rdata_next;
  end

  // ========================================================================
  // Host bit address straight from the selector fields
  always_comb
  begin
    for (int p = 0; p < NPINS; p++)
    begin
      host_bit_pos_o[p] = sel_reg[p][gpm_pkg::SEL_BIT_MSB:gpm_pkg::SEL_BIT_LSB];
      host_page_o[p]    = sel_reg[p][gpm_pkg::SEL_PAGE_MSB:gpm_pkg::SEL_PAGE_LSB];
      host_offset_o[p]  = sel_reg[p][gpm_pkg::SEL_OFS_MSB:gpm_pkg::SEL_OFS_LSB];
    end
  end

  // Per pin mode engines
  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin
    gpm_pin_ctl u_pin (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .mode       (mode_reg[g]),
      .out_val    (out_val_reg[g]),
      .pin_sync   (pin_sync_reg[g]),
      .host_bit   (host_bit_i[g]),
      .pin_drive  (general_pin_out[g]),
      .pin_oe     (general_pin_oe[g]),
      .ctrl_value (ctrl_value_o[g]),
      .ctrl_apply (ctrl_apply_o[g])
    );
  end

  // ========================================================================
  // Checks
  chk_sel_bit_field: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wr_take && idx == gpm_pkg::SEL_IDX[1] && wb_sel_i[1])
      |=> host_bit_pos_o[1] == $past(wb_dat_i[14:12]))
    else $error("selector bit field not routed");

  chk_sel_page_field: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wr_take && idx == gpm_pkg::SEL_IDX[2] && wb_sel_i[1])
      |=> host_page_o[2] == $past(wb_dat_i[11:8]))
    else $error("selector page field not routed");

  chk_sel_offset_field: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wr_take && idx == gpm_pkg::SEL_IDX[3] && wb_sel_i[0])
      |=> host_offset_o[3] == $past(wb_dat_i[6:0]) && sel_reg[3][7] == 1'b0)
    else $error("selector offset field or reserved bit wrong");

  chk_out_value_bits: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wr_take && idx == gpm_pkg::OUT_VAL_IDX && wb_sel_i[0])
      |=> out_val_reg == $past(wb_dat_i[4:0]) ##1 general_pin_out[4] == out_val_reg[4]
          || mode_reg[4] != gpm_pkg::GPM_MODE_OUTPUT)
    else $error("output value bit not stored or not driven");

  chk_mode_field_only: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wr_take && idx == gpm_pkg::MODE_IDX[1] && wb_sel_i[0])
      |=> mode_reg[1] == $past(wb_dat_i[2:0]) && $stable(sel_reg[1]))
    else $error("mode write wrong");

  chk_in_status_level: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode_reg[0] == gpm_pkg::GPM_MODE_INPUT) |=> in_status_reg[0] == $past(pin_sync_reg[0]))
    else $error("input status does not follow the pin");

  chk_ack_single_pulse: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  cov_bus_read: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    wb_ack_o && !wb_we_i && idx == gpm_pkg::IN_STATUS_IDX);
  cov_bus_write_mode: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    wr_take && idx == gpm_pkg::MODE_IDX[2]);

endmodule

// >>> design/gpm_pin_ctl.sv
`timescale 1ns/10ps
// ==========================================================================
// One pin: drive, release, control merge and status mirror
module gpm_pin_ctl (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Configuration
  input  wire logic [2:0] mode,
  input  wire logic       out_val,
  // Pin level (already synchronised) and selected host bit
  input  wire logic       pin_sync,
  input  wire logic       host_bit,
  // Pin drive
  output logic            pin_drive,
  output logic            pin_oe,
  // Control function
  output logic            ctrl_value,
  output logic            ctrl_apply
);

  logic pin_drive_reg;
  logic pin_oe_reg;
  logic ctrl_value_reg;
  logic ctrl_apply_reg;
  logic pin_prev_reg;
  logic host_prev_reg;
  logic changed;

  assign pin_drive  = pin_drive_reg;
  assign pin_oe     = pin_oe_reg;
  assign ctrl_value = ctrl_value_reg;
  assign ctrl_apply = ctrl_apply_reg;
  assign changed    = (pin_sync != pin_prev_reg) || (host_bit != host_prev_reg);

  // Pin drive; unknown codes release the pin so a bad write cannot fight the board
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_drive_reg <= 1'b0;
      pin_oe_reg    <= 1'b0;
    end
    else
    begin
      unique case (gpm_pkg::gpm_mode_t'(mode))
        gpm_pkg::GPM_MODE_OUTPUT:
        begin
          pin_drive_reg <= out_val;
          pin_oe_reg    <= 1'b1;
        end
        gpm_pkg::GPM_MODE_STATUS:
        begin
          pin_drive_reg <= host_bit;
          pin_oe_reg    <= 1'b1;
        end
        default:
        begin
          pin_drive_reg <= 1'b0;
          pin_oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  // Change detect on pin and host bit, merged by OR for the controlled function
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_prev_reg   <= 1'b0;
      host_prev_reg  <= 1'b0;
      ctrl_value_reg <= 1'b0;
      ctrl_apply_reg <= 1'b0;
    end
    else
    begin
      pin_prev_reg   <= pin_sync;
      host_prev_reg  <= host_bit;
      ctrl_value_reg <= pin_sync | host_bit;
      ctrl_apply_reg <= (mode == gpm_pkg::GPM_MODE_CONTROL) && changed;
    end
  end

  // ========================================================================
  // Checks
  property p_output_drive;
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_OUTPUT) |=> (pin_oe && pin_drive == $past(out_val));
  endproperty
  chk_output_drive_value: assert property (p_output_drive)
    else $error("output mode does not drive stored value");

  chk_status_mirror_bit: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_STATUS) ##1 (mode == gpm_pkg::GPM_MODE_STATUS)
      |-> pin_oe && pin_drive == $past(host_bit))
    else $error("status mode does not mirror host bit");

  chk_input_pin_released: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_INPUT) [*2] |-> !pin_oe)
    else $error("input mode still drives the pin");

  chk_control_or_apply: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_CONTROL && $changed(pin_sync))
      |=> ctrl_apply && ctrl_value == ($past(pin_sync) | $past(host_bit)) && !pin_oe)
    else $error("control mode missed a pin change or the OR value");

  cov_output_mode: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_OUTPUT) ##1 pin_oe);
  cov_status_mode: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == gpm_pkg::GPM_MODE_STATUS) && $changed(host_bit));
  cov_control_apply: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    ctrl_apply && ctrl_value);

endmodule

// >>> design/gpm_pkg.sv
// ==========================================================================
// Shared constants for the pin bit mapper
package gpm_pkg;

  // ========================================================================
  // Register indices (byte address is four times the index)
  localparam int unsigned NUM_PINS              = 5;
  localparam logic [8:0]  SEL_IDX [NUM_PINS]    = '{9'h0E0, 9'h0E3, 9'h0E6, 9'h0E9, 9'h0EC};
  localparam logic [8:0]  MODE_IDX [NUM_PINS]   = '{9'h0E2, 9'h0E5, 9'h0E8, 9'h0EB, 9'h0EE};
  localparam logic [8:0]  OUT_VAL_IDX           = 9'h0EF;
  localparam logic [8:0]  IN_STATUS_IDX         = 9'h140;

  // ========================================================================
  // Field layout of a selector word
  localparam int unsigned SEL_BIT_LSB  = 12;
  localparam int unsigned SEL_BIT_MSB  = 14;
  localparam int unsigned SEL_PAGE_LSB = 8;
  localparam int unsigned SEL_PAGE_MSB = 11;
  localparam int unsigned SEL_OFS_LSB  = 0;
  localparam int unsigned SEL_OFS_MSB  = 6;
  localparam logic [15:0] SEL_MASK     = 16'h7F7F;
  localparam logic [7:0]  MODE_MASK    = 8'h07;
  localparam logic [7:0]  PIN_MASK     = 8'h1F;

  // ========================================================================
  // Reset values
  localparam logic [15:0] SEL_RESET     = 16'h0000;
  localparam logic [2:0]  MODE_RESET    = 3'h0;
  localparam logic [4:0]  OUT_VAL_RESET = 5'h00;

  // Mode codes in field order: input, output, control, status
  typedef enum logic [2:0] {
    GPM_MODE_INPUT,
    GPM_MODE_OUTPUT,
    GPM_MODE_CONTROL,
    GPM_MODE_STATUS
  } gpm_mode_t;

endpackage

// >>> verif/gpm_board.sv
`timescale 1ns/10ps
// ==========================================================================
// Board logic on the far side of the general pins
module gpm_board #(
  parameter int unsigned N = 5
) (
  // Design side of each pin
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  // Board drivers, set by the bench
  input  wire logic [N-1:0] drv_en,
  input  wire logic [N-1:0] drv_val,
  // Resolved pin level
  output logic      [N-1:0] pin_level
);
  // Undriven pins float high on pull-ups, so a stale value never survives
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule

// >>> verif/pin_bit_mapper_outputs_bench.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the pin bit mapper
module pin_bit_mapper_outputs_bench;
  logic            core_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [10:0]     wb_adr;
  logic [3:0]      wb_sel;
  logic [31:0]     wb_wdat, wb_rdat, rd;
  logic [4:0]      pin_lvl, pin_out, pin_oe, drv_en, drv_val, host_bit, c_val, c_apply;
  logic [4:0][3:0] h_page;
  logic [4:0][6:0] h_ofs;
  logic [4:0][2:0] h_pos;
  int              error_cnt, comparisons;

  gpm_mapper gpm_mapper_i (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .general_pin_in(pin_lvl),
    .general_pin_out(pin_out), .general_pin_oe(pin_oe), .host_page_o(h_page),
    .host_offset_o(h_ofs), .host_bit_pos_o(h_pos), .host_bit_i(host_bit),
    .ctrl_value_o(c_val), .ctrl_apply_o(c_apply));
  gpm_board gpm_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en),
    .drv_val(drv_val), .pin_level(pin_lvl));

  // ========================================================================
  // Clock and helpers
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release a cycle
  task automatic wb_xfer(input logic [8:0] idx, input logic we, input logic [31:0] wd,
                         input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= sel;
    wb_wdat <= wd;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20)
      chk("bus ack", 32'h0000_0001, 32'h0000_0000);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    wb_xfer(idx, 1'b1, d, 4'h3);
  endtask

  task automatic rd_chk(input string nm, input logic [8:0] idx, input logic [31:0] exp);
    wb_xfer(idx, 1'b0, 32'h0000_0000, 4'hF);
    chk(nm, exp, rd);
  endtask

  task automatic set_modes(input logic [2:0] m);
    for (int i = 0; i < 5; i++)
      wr(gpm_pkg::MODE_IDX[i], {29'h0, m});
    repeat (4) @(posedge core_clk);
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 5; i++)
    begin
      rd_chk("sel reset", gpm_pkg::SEL_IDX[i], 32'h0000_0000);
      rd_chk("mode reset", gpm_pkg::MODE_IDX[i], 32'h0000_0000);
    end
    rd_chk("out reset", gpm_pkg::OUT_VAL_IDX, 32'h0000_0000);
    chk("oe reset", 32'h0000_0000, {27'h0, pin_oe});
    $display("test reset done");
  endtask

  // Pins sit in input mode while selectors are rewritten
  task automatic t_select();
    logic [15:0] v;
    for (int i = 0; i < 5; i++)
    begin
      wr(gpm_pkg::SEL_IDX[i], 32'h0000_FFFF);
      rd_chk("sel mask", gpm_pkg::SEL_IDX[i], 32'h0000_7F7F);
      v = {1'b0, 3'(i + 2), 4'(i + 9), 1'b0, 7'(i * 17 + 3)};
      wr(gpm_pkg::SEL_IDX[i], {16'h0000, v});
      chk("bit pos", {29'h0, 3'(i + 2)}, {29'h0, h_pos[i]});
      chk("page", {28'h0, 4'(i + 9)}, {28'h0, h_page[i]});
      chk("offset", {25'h0, 7'(i * 17 + 3)}, {25'h0, h_ofs[i]});
    end
    $display("test select done");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 5; i++)
    begin
      wr(gpm_pkg::MODE_IDX[i], 32'h0000_00FF);
      rd_chk("mode mask", gpm_pkg::MODE_IDX[i], 32'h0000_0007);
      wr(gpm_pkg::MODE_IDX[i], 32'h0000_0000);
    end
    wr(gpm_pkg::OUT_VAL_IDX, 32'h0000_00FF);
    rd_chk("out mask", gpm_pkg::OUT_VAL_IDX, 32'h0000_001F);
    rd_chk("unmapped", 9'h0F0, 32'h0000_0000);
    $display("test fields done");
  endtask

  task automatic t_output();
    wr(gpm_pkg::OUT_VAL_IDX, 32'h0000_0015);
    set_modes(3'b001);
    chk("out oe", 32'h0000_001F, {27'h0, pin_oe});
    chk("out level", 32'h0000_0015, {27'h0, pin_lvl});
    wr(gpm_pkg::OUT_VAL_IDX, 32'h0000_000A);
    repeat (2) @(posedge core_clk);
    chk("out level", 32'h0000_000A, {27'h0, pin_lvl});
    $display("test output done");
  endtask

  task automatic t_input();
    set_modes(3'b000);
    drv_en  <= 5'h1F;
    drv_val <= 5'h0D;
    repeat (5) @(posedge core_clk);
    chk("in oe", 32'h0000_0000, {27'h0, pin_oe});
    rd_chk("in status", gpm_pkg::IN_STATUS_IDX, 32'h0000_000D);
    drv_en <= 5'h00;
    repeat (5) @(posedge core_clk);
    rd_chk("in pullup", gpm_pkg::IN_STATUS_IDX, 32'h0000_001F);
    $display("test input done");
  endtask

  task automatic t_status();
    host_bit <= 5'h13;
    set_modes(3'b011);
    chk("stat oe", 32'h0000_001F, {27'h0, pin_oe});
    chk("stat level", 32'h0000_0013, {27'h0, pin_lvl});
    host_bit <= 5'h0C;
    repeat (3) @(posedge core_clk);
    chk("stat level", 32'h0000_000C, {27'h0, pin_lvl});
    $display("test status done");
  endtask

  task automatic wait_apply(input int b, input logic [4:0] exp);
    int n;
    n = 0;
    while (c_apply[b] !== 1'b1 && n < 8)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("apply seen", 32'h0000_0001, {31'h0, c_apply[b]});
    chk("ctrl value", {27'h0, exp}, {27'h0, c_val});
  endtask

  task automatic t_control();
    set_modes(3'b000);
    host_bit <= 5'h00;
    drv_en   <= 5'h1F;
    drv_val  <= 5'h00;
    set_modes(3'b010);
    chk("ctrl oe", 32'h0000_0000, {27'h0, pin_oe});
    host_bit <= 5'h04;
    @(posedge core_clk);
    wait_apply(2, 5'h04);
    drv_val <= 5'h08;
    @(posedge core_clk);
    wait_apply(3, 5'h0C);
    $display("test control done");
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ========================================================================
  // Watchdog sized well past the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    rst_b    <= 1'b0;
    wb_cyc   <= 1'b0;
    wb_stb   <= 1'b0;
    wb_we    <= 1'b0;
    wb_adr   <= 11'h000;
    wb_sel   <= 4'h0;
    wb_wdat  <= 32'h0000_0000;
    drv_en   <= 5'h00;
    drv_val  <= 5'h00;
    host_bit <= 5'h00;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_select();
    t_fields();
    t_output();
    t_input();
    t_status();
    t_control();
    wrap_up();
  end
endmodule
